// File: logic/scs_pkg.sv
// Purpose: shared constants for the serial clock and shift block
// Assumes: system clock clk at 20 MHz stands in for fc
// Notes: fs ticks arrive as a one-cycle enable pulse from outside
package scs_pkg;
	localparam logic [2:0] CKSEL_EXTERNAL = 3'h7;
	localparam logic [2:0] CKSEL_SLOWEST = 3'h0;
	// divider exponents for codes 000..110 in high-speed run
	localparam int DIV_EXP_000 = 12;
	localparam int DIV_EXP_001 = 8;
	localparam int DIV_EXP_LAST = 3;
	localparam int FS_DIV_EXP = 4;
	localparam int DIV_WIDTH = 12;
	localparam int BIT_COUNT = 8;
	localparam logic ORDER_MSB_FIRST = 1'b0;
	localparam logic SCK_IDLE = 1'b1;
	localparam logic [7:0] SHIFT_RESET = 8'h00;
	typedef enum logic [1:0] {
		scs_idle,
		scs_low,
		scs_high,
		scs_wait
	} scs_state_t;
endpackage

// File: logic/scs_edge_sync.sv
// Purpose: two-stage synchroniser with edge detect for the external clock
// Assumes: input may be asynchronous to clk
// Notes: first stage is read only by the second stage
module scs_edge_sync (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic din,
	output logic fall,
	output logic rise
);
	logic meta;
	logic sync;
	logic last;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			meta <= 1'b1;
			sync <= 1'b1;
			last <= 1'b1;
		end else begin
			meta <= din;
			sync <= meta;
			last <= sync;
		end
	end

	assign fall = last & ~sync;
	assign rise = ~last & sync;
endmodule

// File: logic/scs_shift_clock.sv
// Purpose: serial clock generation, automatic wait and 8-bit shift timing
// Assumes: buffer handshakes live outside; tx_ready and rx_free tell us
//  whether the next byte may be shifted
// Notes: bytes repeat while start stays high; clock select only while idle
//////////////////////////////////////////////////////////////////////////////
module scs_shift_clock (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic start,
	input wire logic [2:0] clock_select,
	input wire logic bit_order_select,
	input wire logic timebase_divider_select,
	input wire logic low_speed_run_mode,
	input wire logic fs_tick,
	input wire logic [7:0] tx_data,
	input wire logic tx_ready,
	input wire logic rx_free,
	input wire logic serial_clk_in,
	input wire logic serial_in_pin,
	output logic serial_clk_out,
	output logic serial_clk_oe,
	output logic serial_out_pin,
	output logic transfer_active_flag,
	output logic [7:0] rx_data,
	output logic byte_done,
	output logic tx_load,
	output logic select_reserved
);
	logic ext_mode;
	logic ext_fall;
	logic ext_rise;
	logic [11:0] div_cnt;
	logic [11:0] half_limit;
	logic [3:0] fs_cnt;
	logic use_fs;
	logic half_tick;
	logic int_fall;
	logic int_rise;
	logic any_fall;
	logic any_rise;
	logic go_ok;
	logic reserved_now;
	logic [7:0] shreg;
	logic [3:0] bits;
	scs_pkg::scs_state_t state;

	assign ext_mode = (clock_select == scs_pkg::CKSEL_EXTERNAL);
	assign use_fs = (clock_select == scs_pkg::CKSEL_SLOWEST) &&
		(timebase_divider_select || low_speed_run_mode);
	assign go_ok = tx_ready & rx_free;

	scs_edge_sync u_sync (
		.clk(clk),
		.sys_rst(sys_rst),
		.din(serial_clk_in),
		.fall(ext_fall),
		.rise(ext_rise)
	);

	//////////////////////////////////////////////////////////////////////
	// divider: half period ticks
	always_comb begin
		half_limit = 12'h000;
		if (clock_select < scs_pkg::CKSEL_EXTERNAL)
			if (clock_select == scs_pkg::CKSEL_SLOWEST)
				half_limit = 12'(1 << (scs_pkg::DIV_EXP_000 - 1));
			else
				half_limit = 12'(1 << (scs_pkg::DIV_EXP_001 - 1 -
					int'(clock_select) + 1));
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			div_cnt <= 12'h000;
			fs_cnt <= 4'h0;
		end else if (state == scs_pkg::scs_idle ||
			state == scs_pkg::scs_wait) begin
			div_cnt <= 12'h000;
			fs_cnt <= 4'h0;
		end else if (use_fs) begin
			if (fs_tick)
				fs_cnt <= (fs_cnt == 4'h7) ? 4'h0 : fs_cnt + 4'h1;
		end else begin
			div_cnt <= (div_cnt == half_limit - 12'h001) ? 12'h000 :
				div_cnt + 12'h001;
		end
	end

	assign half_tick = use_fs ? (fs_tick && fs_cnt == 4'h7) :
		(div_cnt == half_limit - 12'h001);
	// reserved codes in low-speed run keep the clock parked
	assign reserved_now = low_speed_run_mode &&
		clock_select != scs_pkg::CKSEL_SLOWEST && !ext_mode;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			select_reserved <= 1'b0;
		else
			select_reserved <= reserved_now;
	end

	//////////////////////////////////////////////////////////////////////
	// internal clock sequencer
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state <= scs_pkg::scs_idle;
		end else if (ext_mode || reserved_now) begin
			state <= scs_pkg::scs_idle;
		end else begin
			// wait serves as start-up delay and as the buffer stall
			unique case (state)
			scs_pkg::scs_idle: if (start && go_ok)
				state <= scs_pkg::scs_wait;
			scs_pkg::scs_wait: begin
				if (!start)
					state <= scs_pkg::scs_idle;
				else if (go_ok)
					state <= scs_pkg::scs_low;
			end
			scs_pkg::scs_low: if (half_tick)
				state <= scs_pkg::scs_high;
			scs_pkg::scs_high: if (half_tick) begin
				if (bits != 4'(scs_pkg::BIT_COUNT))
					state <= scs_pkg::scs_low;
				else if (!start)
					state <= scs_pkg::scs_idle;
				else if (go_ok)
					state <= scs_pkg::scs_low;
				else
					state <= scs_pkg::scs_wait;
			end
			endcase
		end
	end

	assign int_fall = !reserved_now && (
		(state == scs_pkg::scs_wait && start && go_ok) ||
		(state == scs_pkg::scs_high && half_tick &&
		!(bits == 4'(scs_pkg::BIT_COUNT) && !(start && go_ok))));
	assign int_rise = state == scs_pkg::scs_low && half_tick;
	assign any_fall = ext_mode ? ext_fall : int_fall;
	assign any_rise = ext_mode ? ext_rise : int_rise;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			serial_clk_out <= scs_pkg::SCK_IDLE;
			serial_clk_oe <= 1'b0;
		end else begin
			serial_clk_oe <= !ext_mode;
			if (!ext_mode && int_fall)
				serial_clk_out <= 1'b0;
			else
				serial_clk_out <= scs_pkg::SCK_IDLE;
			if (!ext_mode && state == scs_pkg::scs_low && !half_tick)
				serial_clk_out <= 1'b0;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// shift datapath
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			shreg <= scs_pkg::SHIFT_RESET;
			bits <= 4'h0;
			serial_out_pin <= 1'b1;
			transfer_active_flag <= 1'b0;
			rx_data <= 8'h00;
			byte_done <= 1'b0;
			tx_load <= 1'b0;
		end else begin
			byte_done <= 1'b0;
			tx_load <= 1'b0;
			if (any_fall && (transfer_active_flag || start)) begin
				transfer_active_flag <= 1'b1;
				if (bits == 4'h0 || bits == 4'(scs_pkg::BIT_COUNT)) begin
					shreg <= tx_data;
					tx_load <= 1'b1;
					bits <= 4'h0;
					serial_out_pin <= (bit_order_select ==
						scs_pkg::ORDER_MSB_FIRST) ?
						tx_data[7] : tx_data[0];
				end else begin
					serial_out_pin <= (bit_order_select ==
						scs_pkg::ORDER_MSB_FIRST) ?
						shreg[7] : shreg[0];
				end
			end
			if (any_rise && transfer_active_flag &&
				bits != 4'(scs_pkg::BIT_COUNT)) begin
				bits <= bits + 4'h1;
				if (bit_order_select == scs_pkg::ORDER_MSB_FIRST)
					shreg <= {shreg[6:0], serial_in_pin};
				else
					shreg <= {serial_in_pin, shreg[7:1]};
				if (bits == 4'(scs_pkg::BIT_COUNT - 1)) begin
					byte_done <= 1'b1;
					rx_data <= (bit_order_select ==
						scs_pkg::ORDER_MSB_FIRST) ?
						{shreg[6:0], serial_in_pin} :
						{serial_in_pin, shreg[7:1]};
				end
			end
			// flag drops once the internal clock is parked high, or without waiting in external clock mode
			if (!start && bits == 4'(scs_pkg::BIT_COUNT) &&
				(ext_mode || state == scs_pkg::scs_idle)) begin
				transfer_active_flag <= 1'b0;
				serial_out_pin <= 1'b1;
				bits <= 4'h0;
			end
		end
	end
endmodule

// File: tb/scs_shift_monitor.sv
// Purpose: port checks for the serial clock block
// Assumes: code 110 half period is 4 clk
// Notes: bound to every scs_shift_clock
module scs_shift_monitor (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [2:0] clock_select,
	input wire logic low_speed_run_mode,
	input wire logic tx_ready,
	input wire logic rx_free,
	input wire logic serial_clk_out,
	input wire logic serial_clk_oe,
	input wire logic serial_out_pin,
	input wire logic transfer_active_flag,
	input wire logic byte_done,
	input wire logic select_reserved
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	idle_high_a: assert property (
		serial_clk_oe && !transfer_active_flag |-> serial_clk_out)
		else $error("clock low while idle");
	oe_code_a: assert property (1 |=> serial_clk_oe ==
		($past(clock_select) != scs_pkg::CKSEL_EXTERNAL))
		else $error("clock drive wrong for code");
	flag_fall_a: assert property (
		serial_clk_oe && $rose(transfer_active_flag) |-> $fell(serial_clk_out))
		else $error("flag rose off a falling edge");
	data_fall_a: assert property (
		serial_clk_oe && !serial_clk_out && $changed(serial_out_pin)
		|-> $fell(serial_clk_out)) else $error("data moved off falling edge");
	rate_a: assert property (
		serial_clk_oe && clock_select == 3'h6 && !low_speed_run_mode &&
		$fell(serial_clk_out) |-> (!serial_clk_out)[*4] ##1 serial_clk_out)
		else $error("half period wrong");
	reserved_a: assert property (
		low_speed_run_mode && clock_select inside {[3'h1:3'h6]}
		|=> select_reserved && serial_clk_out) else $error("reserved code ran");
	stall_a: assert property (
		byte_done && serial_clk_oe && !(tx_ready && rx_free)
		|=> serial_clk_out[*8]) else $error("no wait stall");
	resume_a: assert property (
		serial_clk_oe && transfer_active_flag && clock_select == 3'h6 &&
		$rose(tx_ready && rx_free) |-> ##[1:8] $fell(serial_clk_out))
		else $error("late resume");
endmodule
bind scs_shift_clock scs_shift_monitor mon_u (
	.clk(clk),
	.sys_rst(sys_rst),
	.clock_select(clock_select),
	.low_speed_run_mode(low_speed_run_mode),
	.tx_ready(tx_ready),
	.rx_free(rx_free),
	.serial_clk_out(serial_clk_out),
	.serial_clk_oe(serial_clk_oe),
	.serial_out_pin(serial_out_pin),
	.transfer_active_flag(transfer_active_flag),
	.byte_done(byte_done),
	.select_reserved(select_reserved)
);

// File: tb/scs_peer_model.sv
// Purpose: external serial peer
// Assumes: drives on falling, samples on rising pin edge
// Notes: data line flips once its hold time ends
module scs_peer_model (
	input wire logic sck,
	input wire logic so,
	input wire logic order,
	input wire logic [7:0] tx,
	output logic si,
	output logic [7:0] rx,
	output logic ext_sck
);
	timeunit 1ns;
	timeprecision 1ns;
	int n = 0;
	initial begin
		si = 1'b1;
		ext_sck = 1'b1;
	end
	always @(negedge sck) if ($time > 0) si <= order ? tx[n] : tx[7 - n];
	always @(posedge sck) if ($time > 0) begin
		rx <= order ? {so, rx[7:1]} : {rx[6:0], so};
		n <= (n + 1) % 8;
		if (n == 7) si <= #190 ~si;
	end
	// pulses of 5 clk keep the 4 clk minimum width
	task automatic ext_byte();
		// offset keeps pin edges clear of clk edges
		#10;
		repeat (8) begin
			#250 ext_sck = 1'b0;
			#250 ext_sck = 1'b1;
		end
	endtask
endmodule

// File: tb/tb_top.sv
// Purpose: byte runs over every clock code, stall and reserved code
// Assumes: 50 ns clock, fs tick every 4 clk
// Notes: peer model sits on the pins
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0, sys_rst = 1'b1, start = 1'b0, lsm = 1'b0, dvs = 1'b0;
	logic fs_tick = 1'b0, order = 1'b0, tx_ready = 1'b1, rx_free = 1'b1;
	logic [1:0] fs_cnt = 2'h0;
	logic [2:0] csel = 3'h6;
	logic [7:0] tx_data = 8'h00, peer_tx = 8'h00, rx_data, peer_rx;
	logic sck, ext_sck, si, clk_out, clk_oe, so, flag, done, rsv, load;
	int n_errors = 0, n_tests = 0;
	always #25 clk = ~clk;
	always @(posedge clk) begin
		fs_cnt <= fs_cnt + 2'h1;
		fs_tick <= fs_cnt == 2'h0;
	end
	assign sck = (clk_oe === 1'b1) ? clk_out : ext_sck;
	scs_shift_clock dut_u (.clk(clk), .sys_rst(sys_rst), .start(start),
		.clock_select(csel), .bit_order_select(order),
		.timebase_divider_select(dvs), .low_speed_run_mode(lsm),
		.fs_tick(fs_tick), .tx_data(tx_data), .tx_ready(tx_ready),
		.rx_free(rx_free), .serial_clk_in(sck), .serial_in_pin(si),
		.serial_clk_out(clk_out), .serial_clk_oe(clk_oe), .serial_out_pin(so),
		.transfer_active_flag(flag), .rx_data(rx_data), .byte_done(done),
		.tx_load(load), .select_reserved(rsv));
	scs_peer_model peer_u (.sck(sck), .so(so), .order(order), .tx(peer_tx),
		.si(si), .rx(peer_rx), .ext_sck(ext_sck));
	////////////////////////////////////////////////////////////////////////
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task end_of_test();
		$display("errors=%0d tests=%0d", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task wait_done();
		int k;
		k = 0;
		while (done !== 1'b1 && k < 40000) begin
			@(negedge clk);
			k++;
		end
		chk(done, 1'b1);
	endtask
	task run(input logic [2:0] c, input logic dv, ls, od, input int half);
		int k;
		@(posedge clk);
		csel <= c;
		dvs <= dv;
		lsm <= ls;
		order <= od;
		tx_data <= {5'h15, c};
		peer_tx <= {c, 5'h0B};
		repeat (2) @(posedge clk);
		start <= 1'b1;
		if (c == 3'h7) fork
			peer_u.ext_byte();
			begin
				repeat (12) @(posedge clk);
				start <= 1'b0;
			end
		join
		else begin
			@(negedge clk);
			while (clk_out) @(negedge clk);
			chk(flag, 1'b1);
			chk(load, 1'b1);
			while (!clk_out) @(negedge clk);
			while (clk_out) @(negedge clk);
			k = 0;
			while (!clk_out) begin
				k++;
				@(negedge clk);
			end
			chk(k[15:0], half[15:0]);
			@(posedge clk);
			start <= 1'b0;
		end
		wait_done();
		repeat (half + 4) @(negedge clk);
		chk({flag, clk_out, so, clk_oe}, {3'h3, c != 3'h7});
		chk(rx_data, {c, 5'h0B});
		chk(peer_rx, {5'h15, c});
	endtask
	task stall(input logic use_tx);
		int k;
		run(3'h6, 1'b0, 1'b0, 1'b0, 4);
		@(posedge clk);
		start <= 1'b1;
		repeat (6) @(posedge clk);
		if (use_tx) tx_ready <= 1'b0;
		else rx_free <= 1'b0;
		wait_done();
		repeat (12) @(negedge clk);
		chk({clk_out, flag}, 2'h3);
		@(posedge clk);
		tx_ready <= 1'b1;
		rx_free <= 1'b1;
		k = 0;
		@(negedge clk);
		while (clk_out && k < 20) begin
			k++;
			@(negedge clk);
		end
		chk(k <= 8, 1'b1);
		@(posedge clk);
		start <= 1'b0;
		wait_done();
		chk(rx_data, 8'hCB);
		repeat (8) @(negedge clk);
		chk({flag, clk_out}, 2'h1);
	endtask
	initial begin
		repeat (4) @(posedge clk);
		sys_rst <= 1'b0;
		@(negedge clk);
		chk({clk_out, so, flag}, 3'h6);
		for (int c = 1; c < 7; c++) run(c[2:0], 1'b0, 1'b0, c[0], 1 << (8 - c));
		run(3'h0, 1'b1, 1'b0, 1'b1, 32);
		run(3'h0, 1'b0, 1'b1, 1'b0, 32);
		run(3'h0, 1'b0, 1'b0, 1'b1, 2048);
		run(3'h7, 1'b0, 1'b0, 1'b1, 0);
		stall(1'b1);
		stall(1'b0);
		@(posedge clk);
		lsm <= 1'b1;
		csel <= 3'h3;
		start <= 1'b1;
		repeat (40) @(negedge clk);
		chk({rsv, clk_out, flag}, 3'h6);
		end_of_test();
	end
	initial begin
		repeat (60000) @(posedge clk);
		n_errors++;
		end_of_test();
	end
endmodule
